// File: two_hand_sync_control.sv
// Two-hand safety control: button sync, relay drive, self-monitoring.
// Assumes inputs synchronous to core_clk_i and debounced by wiring.
// Buttons may be NO or NC; relay contacts are read back.
`timescale 1ns/1ps

// Overview of operation
// - Energize only on both buttons within window
// - Single button or late second keeps outputs off
// - Open feedback loop blocks energizing, flags fault once relays settle off, outside POWER_UP and FAULT
// - Any detected error inhibits energizing
// - Release of either button drops outputs after the next sample, within a guard span plus two cycles
// - New cycle needs both released, loop closed
// - Ready only with power and closed loop
// - Switch only when relays read de-energized
// - Faults latched before next actuation can switch
// - Single failure still leaves outputs off
// - Two relays, contact states checked cyclically
// - Line shorts and earth faults block outputs
// - Each button may be normally open or closed
// - Drop outputs well under 20 ms after release
// - Energize well under 20 ms after valid actuation
module two_hand_sync_control #(
    parameter int unsigned SYNC_CYCLES    = two_hand_pkg::SYNC_WINDOW_CYC,
    parameter int unsigned CONTACT_CYCLES = two_hand_pkg::CONTACT_SETTLE_CYC,
    parameter int unsigned TEST_CYCLES    = two_hand_pkg::TEST_PERIOD_CYC
) (
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 power_good_i,
    input  wire two_hand_pkg::hands_s hand_line_i,
    input  wire two_hand_pkg::hands_s hand_nc_i,
    input  wire logic                 earth_fault_i,
    input  wire logic                 contactor_feedback_loop_i,
    input  wire two_hand_pkg::relay_s relay_contact_i,
    output logic                      ready_o,
    output two_hand_pkg::relay_s      relay_o,
    output two_hand_pkg::hands_s      line_drive_o,
    output two_hand_pkg::fault_s      fault_o,
    output two_hand_pkg::phase_e      phase_o
);
    import two_hand_pkg::*;

    // Phase map, one-hot:
    //   POWER_UP waits for power, closed loop, hands off
    //   ARMED    ready, waits for the first press
    //   SYNC     one hand down, window running
    //   ON       both relays driven
    //   LOCKOUT  waits for both hands off
    //   FAULT    sticky error, relays held off
    //   A stray code falls to FAULT

    // ========================================================
    // Constants at counter width
    // ========================================================
    // Limits cut to counter width on purpose
    localparam count_t SYNC_LIMIT    = count_t'(SYNC_CYCLES);
    localparam count_t CONTACT_LIMIT = count_t'(CONTACT_CYCLES);
    localparam count_t TEST_LAST     = count_t'(TEST_CYCLES - 1);
    // Self-test dip length and second line offset
    localparam count_t DIP_LEN       = count_t'(TEST_DIP_CYC);
    localparam count_t SECOND_START  = count_t'(TEST_CYCLES / 2);

    // ========================================================
    // Helpers
    // ========================================================
    // True while the line dip starting at start is low
    function automatic logic in_dip(input count_t cnt, input count_t start);
        in_dip = (cnt >= start) && (cnt < start + DIP_LEN);
    endfunction : in_dip

    // True during a dip and the recovery interval after it
    // Twice the dip, so a line still recovering
    // from its dip is never taken as a press
    function automatic logic in_guard(input count_t cnt,
                                      input count_t start);
        in_guard = (cnt >= start) && (cnt < start + DIP_LEN + DIP_LEN);
    endfunction : in_guard

    // ========================================================
    // State
    // ========================================================
    // Registered state and its next value
    core_state_s s;
    core_state_s next_s;

    // Decoded views, settled each cycle
    hands_s      pressed;
    logic        any_pressed;
    logic        both_pressed;

    // Self-test and fault helpers
    logic        contacts_open;
    logic        settled;
    logic        guard_first;
    logic        guard_second;
    logic        fault_now;
    logic        fault_any;

    // Outputs straight from the state register
    // so every output comes from a flip-flop
    assign ready_o      = s.ready;
    assign relay_o      = s.relay;
    assign line_drive_o = s.line_drive;
    assign fault_o      = s.fault;
    assign phase_o      = s.phase;

    // ========================================================
    // Next state
    // ========================================================
    // One pass builds the whole next state;
    // later sections may override earlier ones
    always_comb begin
        next_s = s;

        // Test dip sequencer for both control lines
        // Counter wraps at the end of each period
        if (s.test_cnt == TEST_LAST) begin
            next_s.test_cnt = CNT_ZERO;
        end else begin
            next_s.test_cnt = s.test_cnt + CNT_ONE;
        end
        next_s.line_drive.first_hand_button =
            !in_dip(s.test_cnt, CNT_ZERO);
        next_s.line_drive.second_hand_button =
            !in_dip(s.test_cnt, SECOND_START);

        // Guard spans freeze the button sample
        guard_first  = in_guard(s.test_cnt, CNT_ZERO);
        guard_second = in_guard(s.test_cnt, SECOND_START);

        // Button sampling, held during dips; NO or NC contact
        if (!guard_first && !guard_second) begin
            next_s.active = hand_line_i ^ hand_nc_i;
        end
        // Decisions use the registered sample
        pressed      = s.active;
        any_pressed  = pressed.first_hand_button |
                       pressed.second_hand_button;
        both_pressed = pressed.first_hand_button &
                       pressed.second_hand_button;

        // Contact settle timer, restarts on every relay change
        settled = (s.settle_cnt >= CONTACT_LIMIT);
        if (!settled) begin
            next_s.settle_cnt = s.settle_cnt + CNT_ONE;
        end
        // Both readback contacts must be open
        contacts_open = !relay_contact_i.relay_a && !relay_contact_i.relay_b;

        // Fault sources; set always wins over a clear
        fault_now = 1'b0;
        // Line still high at dip end means a short
        if (s.test_cnt == DIP_LEN - CNT_ONE &&
            hand_line_i.first_hand_button) begin
            next_s.fault.line_short_first = 1'b1;
            fault_now = 1'b1;
        end
        if (s.test_cnt == SECOND_START + DIP_LEN - CNT_ONE &&
            hand_line_i.second_hand_button) begin
            next_s.fault.line_short_second = 1'b1;
            fault_now = 1'b1;
        end
        // Earth detector is a plain level
        if (earth_fault_i) begin
            next_s.fault.earth_fault = 1'b1;
            fault_now = 1'b1;
        end

        // Each relay judged alone, so one weld is caught
        if (settled && s.relay == RELAY_OFF && !contacts_open) begin
            next_s.fault.contact_stuck = 1'b1;
            fault_now = 1'b1;
        end
        if (settled && s.relay == RELAY_ON &&
            !(relay_contact_i.relay_a && relay_contact_i.relay_b)) begin
            next_s.fault.contact_no_pickup = 1'b1;
            fault_now = 1'b1;
        end

        // Loop must be closed while relays are settled off
        if (settled && s.relay == RELAY_OFF &&
            !contactor_feedback_loop_i && s.phase != ST_POWER_UP &&
            s.phase != ST_FAULT) begin
            next_s.fault.feedback_open = 1'b1;
            fault_now = 1'b1;
        end

        // New or latched fault blocks switching
        fault_any = fault_now || (s.fault != FAULT_NONE);

        // Sequencer
        case (s.phase)
            // Wait for power, closed loop, hands off
            ST_POWER_UP: begin
                if (fault_any) begin
                    next_s.phase = ST_FAULT;
                end else if (power_good_i && contactor_feedback_loop_i &&
                             !any_pressed && contacts_open) begin
                    next_s.phase = ST_ARMED;
                end
            end

            // Ready; first press starts the window
            ST_ARMED: begin
                next_s.sync_cnt = CNT_ZERO;
                if (fault_any) begin
                    next_s.phase = ST_FAULT;
                end else if (!power_good_i ||
                             !contactor_feedback_loop_i) begin
                    next_s.phase = ST_POWER_UP;
                end else if (both_pressed && contacts_open) begin
                    next_s.phase = ST_ON;
                end else if (any_pressed) begin
                    next_s.phase = ST_SYNC;
                end
            end

            // One hand down, window running
            ST_SYNC: begin
                next_s.sync_cnt = s.sync_cnt + CNT_ONE;
                if (fault_any) begin
                    next_s.phase = ST_FAULT;
                end else if (!power_good_i) begin
                    next_s.phase = ST_POWER_UP;
                end else if (!any_pressed && contactor_feedback_loop_i) begin
                    next_s.phase    = ST_ARMED;
                    next_s.sync_cnt = CNT_ZERO;
                end else if (both_pressed && contacts_open &&
                             contactor_feedback_loop_i) begin
                    next_s.phase = ST_ON;
                // Window expired or loop opened
                end else if (next_s.sync_cnt >= SYNC_LIMIT ||
                             !contactor_feedback_loop_i) begin
                    next_s.phase = ST_LOCKOUT;
                end
            end

            // Relays driven while both hands stay
            ST_ON: begin
                if (fault_any) begin
                    next_s.phase = ST_FAULT;
                end else if (!both_pressed || !power_good_i) begin
                    next_s.phase = ST_LOCKOUT;
                end
            end

            // Wait for both hands off and contacts at rest
            ST_LOCKOUT: begin
                next_s.sync_cnt = CNT_ZERO;
                if (fault_any) begin
                    next_s.phase = ST_FAULT;
                end else if (!any_pressed && contactor_feedback_loop_i &&
                             contacts_open && settled) begin
                    next_s.phase = ST_POWER_UP;
                end
            end

            ST_FAULT: begin
                // Clear only when every source is gone and hands off
                // A new fault in the same cycle wins over the clear
                if (!fault_now && !any_pressed && !earth_fault_i &&
                    contacts_open && contactor_feedback_loop_i &&
                    settled) begin
                    next_s.fault = FAULT_NONE;
                    next_s.phase = ST_POWER_UP;
                end
            end

            // Illegal code lands in the safe phase
            default: begin
                next_s.phase = ST_FAULT;
            end
        endcase

        // Both relays follow the ON phase only
        if (next_s.phase == ST_ON) begin
            next_s.relay = RELAY_ON;
        end else begin
            next_s.relay = RELAY_OFF;
        end

        // Settle timer restarts on every relay edge
        if (next_s.relay != s.relay) begin
            next_s.settle_cnt = CNT_ZERO;
        end
        // Ready only while waiting for hands
        next_s.ready = (next_s.phase == ST_ARMED) ||
                       (next_s.phase == ST_SYNC);
    end

    // ========================================================
    // State register
    // ========================================================
    // Synchronous reset to the safe state
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            s <= STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

endmodule : two_hand_sync_control

// File: two_hand_pkg.sv
// Constants, types and state layout for the two-hand safety control.
// Assumes a single 125 MHz clock and synchronous active-low reset.
package two_hand_pkg;

    // ========================================================
    // Timing
    // ========================================================
    localparam int unsigned CLK_FREQ_KHZ      = 125000;
    // Synchronisation window, longest time, rounds down
    localparam int unsigned SYNC_WINDOW_MS    = 500;
    localparam int unsigned SYNC_WINDOW_CYC   = SYNC_WINDOW_MS * CLK_FREQ_KHZ;
    // Relay contact settle time before readback is judged
    localparam int unsigned CONTACT_SETTLE_MS = 10;
    localparam int unsigned CONTACT_SETTLE_CYC =
        CONTACT_SETTLE_MS * CLK_FREQ_KHZ;
    // Period of the control line test dips
    localparam int unsigned TEST_PERIOD_MS    = 1;
    localparam int unsigned TEST_PERIOD_CYC   = TEST_PERIOD_MS * CLK_FREQ_KHZ;
    // Width of one test dip, least time, rounds up
    localparam int unsigned TEST_DIP_US       = 2;
    localparam int unsigned TEST_DIP_CYC      =
        (TEST_DIP_US * CLK_FREQ_KHZ + 999) / 1000;
    // Release and response limits the design keeps (within two test dips and a few cycles)
    localparam int unsigned RESPONSE_LIMIT_MS = 20;

    // ========================================================
    // Counters
    // ========================================================
    localparam int          CNT_W    = 26;
    typedef logic [CNT_W-1:0] count_t;
    localparam count_t      CNT_ZERO = 26'h0000000;
    localparam count_t      CNT_ONE  = 26'h0000001;

    // ========================================================
    // Types
    // ========================================================
    typedef enum logic [5:0] {
        ST_POWER_UP = 6'h01,
        ST_ARMED    = 6'h02,
        ST_SYNC     = 6'h04,
        ST_ON       = 6'h08,
        ST_LOCKOUT  = 6'h10,
        ST_FAULT    = 6'h20
    } phase_e;

    typedef struct packed {
        logic first_hand_button;
        logic second_hand_button;
    } hands_s;

    typedef struct packed {
        logic relay_a;
        logic relay_b;
    } relay_s;

    typedef struct packed {
        logic line_short_first;
        logic line_short_second;
        logic earth_fault;
        logic contact_stuck;
        logic contact_no_pickup;
        logic feedback_open;
    } fault_s;

    typedef struct packed {
        phase_e phase;
        count_t sync_cnt;
        count_t settle_cnt;
        count_t test_cnt;
        hands_s active;
        hands_s line_drive;
        fault_s fault;
        relay_s relay;
        logic   ready;
    } core_state_s;

    localparam hands_s HANDS_OFF  = 2'h0;
    localparam hands_s HANDS_ON   = 2'h3;
    localparam relay_s RELAY_OFF  = 2'h0;
    localparam relay_s RELAY_ON   = 2'h3;
    localparam fault_s FAULT_NONE = 6'h00;

    localparam core_state_s STATE_RESET = '{
        phase:      ST_POWER_UP,
        sync_cnt:   CNT_ZERO,
        settle_cnt: CNT_ZERO,
        test_cnt:   CNT_ZERO,
        active:     HANDS_OFF,
        line_drive: HANDS_ON,
        fault:      FAULT_NONE,
        relay:      RELAY_OFF,
        ready:      1'b0
    };

endpackage : two_hand_pkg

// File: two_hand_sva.sv
// Port checker for the two-hand safety control.
// Assumes binding onto two_hand_sync_control, one clock domain.
`timescale 1ns/1ps
module two_hand_sva #(
    parameter int unsigned SYNC_CYCLES    = 200,
    parameter int unsigned CONTACT_CYCLES = 20,
    parameter int unsigned TEST_CYCLES    = 2000
) (
    input wire logic                 core_clk_i,
    input wire logic                 rst_n_i,
    input wire logic                 power_good_i,
    input wire two_hand_pkg::hands_s hand_line_i,
    input wire two_hand_pkg::hands_s hand_nc_i,
    input wire logic                 earth_fault_i,
    input wire logic                 contactor_feedback_loop_i,
    input wire two_hand_pkg::relay_s relay_contact_i,
    input wire logic                 ready_o,
    input wire two_hand_pkg::relay_s relay_o,
    input wire two_hand_pkg::hands_s line_drive_o,
    input wire two_hand_pkg::fault_s fault_o,
    input wire two_hand_pkg::phase_e phase_o
);
    import two_hand_pkg::*;

    hands_s      pressed;
    int unsigned sync_run;

    // Button levels as pressed, per contact type
    assign pressed = hand_line_i ^ hand_nc_i;

    // Cycles spent waiting for the second hand
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || phase_o != ST_SYNC) begin
            sync_run <= 0;
        end else begin
            sync_run <= sync_run + 1;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ========================================================
    // Port relations
    // ========================================================
    AST_RELAY_PAIR: assert property (
        relay_o.relay_a == relay_o.relay_b)
        else $error("Relay outputs differ");
    AST_FAULT_OFF: assert property (
        |fault_o |=> relay_o == RELAY_OFF)
        else $error("Relay on with fault");
    AST_FAULT_PHASE: assert property (
        |fault_o |-> ##[0:1] phase_o == ST_FAULT)
        else $error("Fault without fault phase");
    AST_RELEASE: assert property (
        relay_o == RELAY_ON && line_drive_o == HANDS_ON &&
        pressed != HANDS_ON
        |-> ##[1:520] relay_o == RELAY_OFF)
        else $error("Relay held after release");
    AST_ON_FROM_READY: assert property (
        $rose(relay_o.relay_a) |-> $past(phase_o) inside {ST_ARMED, ST_SYNC}
        && $past(relay_contact_i) == RELAY_OFF)
        else $error("Relay on from wrong state");
    AST_ON_CLEAN: assert property (
        $rose(relay_o.relay_a) |-> $past(contactor_feedback_loop_i)
        && $past(fault_o) == FAULT_NONE)
        else $error("Relay on with loop open or fault");
    AST_ON_BOTH: assert property (
        $rose(relay_o.relay_a) |-> $past(pressed) == HANDS_ON)
        else $error("Relay on without both hands");
    AST_SYNC_WINDOW: assert property (
        sync_run <= SYNC_CYCLES + 1)
        else $error("Sync wait too long");
    AST_READY_LOOP: assert property (
        ready_o |-> $past(contactor_feedback_loop_i))
        else $error("Ready with loop open");
    AST_DIP_ALTERNATE: assert property (
        !line_drive_o.first_hand_button |-> line_drive_o.second_hand_button)
        else $error("Both lines dipped");
endmodule : two_hand_sva

bind two_hand_sync_control two_hand_sva #(
    .SYNC_CYCLES(SYNC_CYCLES), .CONTACT_CYCLES(CONTACT_CYCLES),
    .TEST_CYCLES(TEST_CYCLES)
) u_sva (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .power_good_i(power_good_i), .hand_line_i(hand_line_i),
    .hand_nc_i(hand_nc_i), .earth_fault_i(earth_fault_i),
    .contactor_feedback_loop_i(contactor_feedback_loop_i),
    .relay_contact_i(relay_contact_i), .ready_o(ready_o),
    .relay_o(relay_o), .line_drive_o(line_drive_o),
    .fault_o(fault_o), .phase_o(phase_o)
);

// File: hand_station_model.sv
// Operator buttons and downstream contactor beside the control.
// Assumes level inputs, no bounce; faults injected by the bench.
`timescale 1ns/1ps
module hand_station_model (
    input  wire two_hand_pkg::hands_s press_i,
    input  wire two_hand_pkg::hands_s nc_i,
    input  wire two_hand_pkg::hands_s line_drive_i,
    input  wire two_hand_pkg::relay_s relay_i,
    input  wire logic                 short_first_i,
    input  wire logic                 weld_i,
    input  wire logic                 loop_break_i,
    output two_hand_pkg::hands_s      hand_line_o,
    output two_hand_pkg::relay_s      contact_o,
    output logic                      loop_o
);
    import two_hand_pkg::*;

    // Line conducts when supplied and contact closed; short holds it up
    assign hand_line_o = (line_drive_i & (press_i ^ nc_i))
        | {short_first_i, 1'b0};
    // Readback follows relays unless welded
    assign contact_o = relay_i | {2{weld_i}};
    // Guided contacts close the loop only at rest
    assign loop_o = (relay_i == RELAY_OFF) & !loop_break_i;
endmodule : hand_station_model

// File: two_hand_sync_control_tb.sv
// Self-checking bench for the two-hand safety control.
// Assumes the bound checker and the station model beside the design.
`timescale 1ns/1ps
module two_hand_sync_control_tb;
    import two_hand_pkg::*;

    typedef struct packed {
        hands_s     nc;
        logic [9:0] gap;
        logic       two;
        logic       on;
    } row_s;
    typedef struct packed {
        logic [2:0] inj;
        fault_s     mask;
    } flt_s;

    logic       core_clk_i, rst_n_i, power_good_i, brk;
    logic       contactor_feedback_loop_i, ready_o;
    logic [2:0] inj; // Weld, short, earth
    hands_s     press, hand_nc_i, hand_line_i, line_drive_o;
    relay_s     relay_contact_i, relay_o;
    fault_s     fault_o;
    phase_e     phase_o;
    int         num_errors, check_count;
    row_s       rows [5] = '{'{2'h0, 10'h000, 1'b1, 1'b1},
        '{2'h1, 10'h032, 1'b1, 1'b1}, '{2'h2, 10'h0be, 1'b1, 1'b1},
        '{2'h3, 10'h0d2, 1'b1, 1'b0}, '{2'h0, 10'h000, 1'b0, 1'b0}};
    flt_s       flts [3] = '{'{3'h1, 6'h08}, '{3'h2, 6'h20},
        '{3'h4, 6'h04}};

    // Clock, 8 ns period
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    two_hand_sync_control #(
        .SYNC_CYCLES(200), .CONTACT_CYCLES(20), .TEST_CYCLES(2000)
    ) u_dut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .power_good_i(power_good_i), .hand_line_i(hand_line_i),
        .hand_nc_i(hand_nc_i), .earth_fault_i(inj[0]),
        .contactor_feedback_loop_i(contactor_feedback_loop_i),
        .relay_contact_i(relay_contact_i), .ready_o(ready_o),
        .relay_o(relay_o), .line_drive_o(line_drive_o),
        .fault_o(fault_o), .phase_o(phase_o)
    );

    hand_station_model u_model (
        .press_i(press), .nc_i(hand_nc_i), .line_drive_i(line_drive_o),
        .relay_i(relay_o), .short_first_i(inj[1]), .weld_i(inj[2]),
        .loop_break_i(brk), .hand_line_o(hand_line_i),
        .contact_o(relay_contact_i), .loop_o(contactor_feedback_loop_i)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : tick

    task automatic check(input string what, input logic [7:0] exp, got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask : check

    task automatic wait_relay(input relay_s v, input int lim);
        for (int n = 0; n < lim && relay_o !== v; n++) tick(1);
    endtask : wait_relay

    task automatic wait_ready(input int lim);
        for (int n = 0; n < lim && ready_o !== 1'b1; n++) tick(1);
    endtask : wait_ready

    // Start just after the second line's dip and recovery, inside a sampling span
    task automatic align();
        for (int n = 0; n < 2100 && line_drive_o[0] !== 1'b0; n++) tick(1);
        for (int n = 0; n < 300 && line_drive_o[0] !== 1'b1; n++) tick(1);
        tick(255);
    endtask : align

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    // Main sequence
    initial begin
        rst_n_i = 1'b0;
        power_good_i = 1'b1;
        press = HANDS_OFF;
        hand_nc_i = HANDS_OFF;
        inj = 3'h0;
        brk = 1'b0;
        tick(2);
        check("reset phase", ST_POWER_UP, phase_o);
        check("reset relay", RELAY_OFF, relay_o);
        check("reset drive", HANDS_ON, line_drive_o);
        check("reset fault", FAULT_NONE, fault_o);
        rst_n_i = 1'b1;
        wait_ready(10);
        check("ready", 1'b1, ready_o);
        $display("Reset test done");
        foreach (rows[i]) begin
            hand_nc_i = rows[i].nc;
            wait_ready(600);
            align();
            if (rows[i].gap == 10'h000) begin
                press = {1'b1, rows[i].two};
            end else begin
                press.first_hand_button = 1'b1;
                tick(rows[i].gap);
                press.second_hand_button = rows[i].two;
            end
            wait_relay(RELAY_ON, 20);
            check("relay", rows[i].on ? RELAY_ON : RELAY_OFF, relay_o);
            press.first_hand_button = 1'b0;
            wait_relay(RELAY_OFF, 520);
            check("relay drop", RELAY_OFF, relay_o);
            tick(1);
            press = HANDS_OFF;
            wait_ready(600);
            check("rearm", 1'b1, ready_o);
            $display("Row %0d done", i);
        end
        align();
        press = HANDS_ON;
        wait_relay(RELAY_ON, 20);
        press.first_hand_button = 1'b0;
        wait_relay(RELAY_OFF, 520);
        press.first_hand_button = 1'b1;
        tick(600);
        check("no restart", RELAY_OFF, relay_o);
        press = HANDS_OFF;
        wait_ready(600);
        $display("Restart test done");
        power_good_i = 1'b0;
        tick(5);
        check("ready unpowered", 1'b0, ready_o);
        power_good_i = 1'b1;
        brk = 1'b1;
        tick(5);
        check("ready loop open", 1'b0, ready_o);
        brk = 1'b0;
        wait_ready(600);
        align();
        press.first_hand_button = 1'b1;
        tick(5);
        brk = 1'b1;
        press.second_hand_button = 1'b1;
        tick(600);
        check("relay loop open", RELAY_OFF, relay_o);
        check("loop fault", 1'b1, fault_o.feedback_open);
        press = HANDS_OFF;
        brk = 1'b0;
        wait_ready(600);
        check("rearm loop", 1'b1, ready_o);
        $display("Loop test done");
        foreach (flts[i]) begin
            inj = flts[i].inj;
            for (int n = 0; n < 4500 && (fault_o & flts[i].mask) == 0; n++)
                tick(1);
            check("fault", flts[i].mask, fault_o & flts[i].mask);
            align();
            press = HANDS_ON;
            tick(600);
            check("relay faulted", RELAY_OFF, relay_o);
            press = HANDS_OFF;
            inj = 3'h0;
            wait_ready(4500);
            check("rearm fault", 1'b1, ready_o);
            $display("Fault %0d done", i);
        end
        align();
        press = HANDS_ON;
        wait_relay(RELAY_ON, 20);
        check("relay mid", RELAY_ON, relay_o);
        rst_n_i = 1'b0;
        tick(2);
        check("reset relay mid", RELAY_OFF, relay_o);
        check("reset phase mid", ST_POWER_UP, phase_o);
        press = HANDS_OFF;
        rst_n_i = 1'b1;
        wait_ready(600);
        check("rearm reset", 1'b1, ready_o);
        $display("Mid reset test done");
        close_out();
    end

    // Watchdog against a hang
    initial begin
        repeat (80000) @(posedge core_clk_i);
        num_errors++;
        close_out();
    end
endmodule : two_hand_sync_control_tb
